// >>> dpram_arbiter.sv
`timescale 1ns/1ns
`default_nettype none
module dpram_arbiter
    import serial_dma_channel_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic srst,
    input  wire logic host_req,
    input  wire logic cp_req,
    output var  logic host_gnt,
    output var  logic cp_gnt
);

    // ------------------------------------------------------------------
    // Host access takes four clocks; the co-processor owns three of them.
    // ------------------------------------------------------------------
    logic [2:0] host_cnt_q;
    logic [2:0] host_cnt_d;
    logic       host_slot;
    logic       cp_wait_q;

    assign host_slot  = host_req && (host_cnt_q == HOST_CNT_LAST || !cp_req || cp_wait_q);
    assign host_cnt_d = !host_req ? 3'h0 :
                        (host_cnt_q == HOST_CNT_LAST) ? 3'h0 : host_cnt_q + 3'h1;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            host_cnt_q <= 3'h0;
            cp_wait_q  <= 1'b0;
        end else begin
            host_cnt_q <= host_cnt_d;
            cp_wait_q  <= cp_req && host_slot && !cp_wait_q;
        end
    end

    // Co-processor holds off at most one clock, never both in one cycle.
    assign cp_gnt   = cp_req && !(host_slot && !cp_wait_q);
    assign host_gnt = host_slot && !cp_gnt;

endmodule : dpram_arbiter
`default_nettype wire

// >>> host_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_bus_model
    import serial_dma_channel_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic       req,
    input  wire logic       slow,
    input  wire logic       err_en,
    input  wire bus_cycle_t cyc,
    output var  logic       gnt,
    output var  logic       done,
    output var  logic       err
);
    // --------------------
    // Arbiter and memory
    // --------------------
    logic [3:0] wait_q;
    wire busy  = (req && !gnt) || (cyc.active && !done);
    wire ready = wait_q >= (slow ? 4'h5 : 4'h0);
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wait_q <= 4'h0;
            gnt    <= 1'b0;
            done   <= 1'b0;
            err    <= 1'b0;
        end else begin
            wait_q <= busy ? wait_q + 4'h1 : 4'h0;
            gnt    <= req && ready && !cyc.active;
            done   <= cyc.active && !done && ready;
            err    <= cyc.active && !done && ready && err_en;
        end
    end
endmodule : host_bus_model
`default_nettype wire

// >>> serial_dma_channel_pkg.sv
package serial_dma_channel_pkg;

    // ------------------------------------------------------------------
    // Request sources and scheduler sizes
    // ------------------------------------------------------------------
    localparam int NUM_REQ        = 16;
    localparam int REQ_IDX_W      = 4;
    localparam int NUM_CHAN       = 6;
    localparam int CHAN_W         = 3;
    localparam int FC_W           = 3;
    localparam int ADDR_W         = 24;

    localparam logic [3:0] REQ_RESET    = 4'h0;
    localparam logic [3:0] REQ_BUS_ERR  = 4'h1;
    localparam logic [3:0] REQ_REFRESH  = 4'h2;
    localparam logic [3:0] REQ_COMMAND  = 4'h3;
    localparam logic [3:0] REQ_SCC1_RX  = 4'h4;
    localparam logic [3:0] REQ_SCC3_TX  = 4'h9;

    // Bus error channel codes; refresh shares the first receive channel code.
    localparam logic [3:0] BUS_ERROR_CHANNEL_CODE_CODE_REFRESH = 4'h1;
    localparam logic [3:0] BUS_ERROR_CHANNEL_CODE_CODE_BASE    = 4'h1;

    // Dual-port RAM host access length and the most co-processor slots in it.
    localparam int HOST_ACC_CLKS  = 4;
    localparam int CP_SLOTS_MAX   = 3;
    localparam logic [2:0] HOST_CNT_LAST = 3'h3;

    // Transfer sizes.
    localparam logic SIZE_BYTE    = 1'b0;
    localparam logic SIZE_WORD    = 1'b1;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              valid;
        logic              to_external;
        logic              is_write;
        logic              wide_proto;
        logic [ADDR_W-1:0] addr;
    } chan_req_t;

    typedef struct packed {
        logic              active;
        logic              write;
        logic              word;
        logic              upper;
        logic [FC_W-1:0]   fc;
        logic [ADDR_W-1:0] addr;
    } bus_cycle_t;

    typedef enum logic [2:0] {
        BUS_IDLE  = 3'b000,
        BUS_REQ   = 3'b001,
        BUS_ACK   = 3'b011,
        BUS_CYC   = 3'b010,
        BUS_CYC2  = 3'b110,
        BUS_DONE  = 3'b111
    } bus_state_t;

    function automatic logic [REQ_IDX_W-1:0] first_set(input logic [NUM_REQ-1:0] v);
        logic [REQ_IDX_W-1:0] r;
        r = '0;
        for (int i = NUM_REQ - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = REQ_IDX_W'(i);
            end
        end
        return r;
    endfunction : first_set

endpackage : serial_dma_channel_pkg

// >>> serial_dma_channel_sched_properties.sv
`timescale 1ns/1ns
`default_nettype none
module serial_dma_channel_sched_checker
    import serial_dma_channel_pkg::*;
(
    input wire logic                 core_clk,
    input wire logic                 srst,
    input wire logic                 routine_done,
    input wire logic                 byte_bus,
    input wire logic                 cp_dpram_req,
    input wire logic                 independent_dma_unit_owns_bus,
    input wire logic                 serial_dma_bus_grant_internal,
    input wire logic                 routine_valid,
    input wire logic [REQ_IDX_W-1:0] routine_sel,
    input wire logic                 serial_dma_bus_request_internal,
    input wire logic                 bus_grant_acknowledge_out,
    input wire logic                 bus_clear_out,
    input wire bus_cycle_t           bus_cycle,
    input wire logic                 bus_error_valid,
    input wire logic [3:0]           bus_error_channel_code,
    input wire logic                 dpram_host_gnt,
    input wire logic                 dpram_cp_gnt
);
    // --------------------
    // Checks
    // --------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence s_granted;
        serial_dma_bus_request_internal && serial_dma_bus_grant_internal;
    endsequence
    sequence s_cp_held_off;
        cp_dpram_req && !dpram_cp_gnt ##1 cp_dpram_req;
    endsequence
    AST_DPRAM_EXCL: assert property (!(dpram_host_gnt && dpram_cp_gnt))
        else $error("shared ram granted to both");
    AST_CP_WAIT: assert property (s_cp_held_off |-> dpram_cp_gnt)
        else $error("ram wait over one cycle");
    AST_ACK_AFTER_GNT: assert property (s_granted |=>
        bus_grant_acknowledge_out && !serial_dma_bus_request_internal)
        else $error("no acknowledge after grant");
    AST_CLEAR_ON_REQ: assert property (serial_dma_bus_request_internal &&
        !independent_dma_unit_owns_bus |-> bus_clear_out) else $error("no clear on request");
    AST_CLEAR_OFF_CYC: assert property (bus_cycle.active |-> !bus_clear_out)
        else $error("clear during access");
    AST_INDEPENDENT_DMA_UNIT_NO_CLEAR: assert property (independent_dma_unit_owns_bus |-> !bus_clear_out)
        else $error("clear while dma unit owns bus");
    AST_READ_WIDE: assert property (bus_cycle.active && !bus_cycle.write && !byte_bus &&
        routine_sel != REQ_REFRESH |-> bus_cycle.word) else $error("narrow read");
    AST_INTERNAL_ONLY: assert property (routine_valid && routine_sel > REQ_SCC3_TX |->
        !serial_dma_bus_request_internal && !bus_cycle.active) else $error("byte port on bus");
    AST_HOLD_ROUTINE: assert property (routine_valid && !routine_done |=>
        routine_valid && $stable(routine_sel)) else $error("routine preempted");
    AST_REFRESH_CODE: assert property ($rose(bus_error_valid) &&
        routine_sel == REQ_REFRESH |-> bus_error_channel_code == 4'h1)
        else $error("refresh error code wrong");
endmodule : serial_dma_channel_sched_checker
bind serial_dma_request_scheduler serial_dma_channel_sched_checker u_chk (.core_clk, .srst, .routine_done,
    .byte_bus, .cp_dpram_req, .independent_dma_unit_owns_bus, .serial_dma_bus_grant_internal,
    .routine_valid, .routine_sel, .serial_dma_bus_request_internal, .bus_grant_acknowledge_out,
    .bus_clear_out, .bus_cycle, .bus_error_valid, .bus_error_channel_code, .dpram_host_gnt,
    .dpram_cp_gnt);
`default_nettype wire

// >>> serial_dma_request_scheduler.sv
`timescale 1ns/1ns
`default_nettype none
module serial_dma_request_scheduler
    import serial_dma_channel_pkg::*;
(
    input  wire logic                         core_clk,
    input  wire logic                         srst,
    input  wire logic                         cp_reset_req,
    input  wire logic                         refresh_req,
    input  wire logic [ADDR_W-1:0]            refresh_addr,
    input  wire logic [FC_W-1:0]              refresh_fc,
    input  wire logic                         command_req,
    input  wire logic [11:0]                  fifo_req,
    input  wire chan_req_t [NUM_CHAN-1:0]     chan_req,
    input  wire logic [NUM_CHAN*FC_W-1:0]     chan_fc,
    input  wire logic                         routine_done,
    input  wire logic                         serial_dma_bus_grant_internal,
    input  wire logic                         independent_dma_unit_owns_bus,
    input  wire logic                         bus_cycle_done,
    input  wire logic                         bus_error,
    input  wire logic                         bus_halt,
    input  wire logic                         bus_retry,
    input  wire logic                         byte_bus,
    input  wire logic                         low_latency_bus_clear_mode,
    input  wire logic                         host_dpram_req,
    input  wire logic                         cp_dpram_req,
    output var  logic                         routine_valid,
    output var  logic [REQ_IDX_W-1:0]         routine_sel,
    output var  logic                         serial_dma_bus_request_internal,
    output var  logic                         bus_grant_acknowledge_out,
    output var  logic                         bus_clear_out,
    output var  bus_cycle_t                   bus_cycle,
    output var  logic                         bus_error_valid,
    output var  logic [3:0]                   bus_error_channel_code,
    output var  logic                         dpram_host_gnt,
    output var  logic                         dpram_cp_gnt,
    output var  logic                         chan_done
);

    // ------------------------------------------------------------------
    // Priority scheduler
    // ------------------------------------------------------------------
    logic [NUM_REQ-1:0]   pending;
    logic                 busy_q;
    logic [REQ_IDX_W-1:0] sel_q;
    logic [REQ_IDX_W-1:0] pick;
    logic                 bus_err_pend_q;
    logic                 start;

    assign pending = {fifo_req, command_req, refresh_req, bus_err_pend_q, cp_reset_req};
    assign pick    = first_set(pending);
    assign start   = !busy_q && (|pending);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            busy_q <= 1'b0;
            sel_q  <= '0;
        end else if (start) begin
            busy_q <= 1'b1;
            sel_q  <= pick;
        end else if (busy_q && routine_done) begin
            busy_q <= 1'b0;
        end
    end

    assign routine_valid = busy_q;
    assign routine_sel   = sel_q;

    // ------------------------------------------------------------------
    // Channel selection; the six channels belong to the three controllers
    // ------------------------------------------------------------------
    // The management and sync port requests have no channel and never go out.
    logic                is_chan_sel;
    logic                is_refresh_sel;
    logic [CHAN_W-1:0]   chan_idx;
    chan_req_t           cur_req;
    logic [FC_W-1:0]     cur_fc;
    logic                want_ext;
    logic                want_int;

    assign is_chan_sel    = (sel_q >= REQ_SCC1_RX) && (sel_q <= REQ_SCC3_TX);
    assign is_refresh_sel = (sel_q == REQ_REFRESH);
    assign chan_idx       = CHAN_W'(sel_q - REQ_SCC1_RX);
    assign cur_req        = chan_req[chan_idx];
    assign cur_fc         = chan_fc[chan_idx*FC_W +: FC_W];
    assign want_ext       = busy_q && ((is_chan_sel && cur_req.valid && cur_req.to_external)
                            || is_refresh_sel);
    assign want_int       = busy_q && is_chan_sel && cur_req.valid && !cur_req.to_external;

    // ------------------------------------------------------------------
    // Host bus cycle stealer
    // ------------------------------------------------------------------
    bus_state_t state_q;
    bus_state_t state_d;
    logic       word_op;
    logic       abort;
    logic       launch;

    // Reads are words except refresh, which is a byte; writes bytes unless the protocol is a wide one.
    assign word_op = is_refresh_sel ? SIZE_BYTE :
                     (!cur_req.is_write ? SIZE_WORD : cur_req.wide_proto);
    assign abort   = bus_error || bus_retry;
    assign launch  = want_ext && !chan_done;

    // The mode bit is not an input of any decision here.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            BUS_IDLE: begin
                if (launch && !bus_halt) begin
                    state_d = BUS_REQ;
                end
            end
            BUS_REQ: begin
                if (serial_dma_bus_grant_internal) begin
                    state_d = BUS_ACK;
                end
            end
            BUS_ACK: begin
                state_d = BUS_CYC;
            end
            BUS_CYC: begin
                if (abort) begin
                    state_d = BUS_DONE;
                end else if (bus_cycle_done) begin
                    state_d = (word_op && byte_bus && !bus_halt) ? BUS_CYC2 : BUS_DONE;
                end
            end
            BUS_CYC2: begin
                if (abort || bus_cycle_done) begin
                    state_d = BUS_DONE;
                end
            end
            BUS_DONE: begin
                state_d = BUS_IDLE;
            end
            default: begin
                state_d = BUS_IDLE;
            end
        endcase
    end

    logic chan_done_q;

    always_ff @(posedge core_clk) begin
        if (srst || cp_reset_req) begin
            state_q <= BUS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst || cp_reset_req) begin
            serial_dma_bus_request_internal <= 1'b0;
            bus_grant_acknowledge_out       <= 1'b0;
            bus_clear_out                   <= 1'b0;
            bus_cycle                       <= '0;
            chan_done_q                     <= 1'b0;
        end else begin
            serial_dma_bus_request_internal <= (state_d == BUS_REQ);
            // Acknowledge only after grant; owned continuously across a steal.
            bus_grant_acknowledge_out <= (state_d == BUS_ACK) || (state_d == BUS_CYC)
                                         || (state_d == BUS_CYC2);
            // Clear goes out with the request, not when stealing from the
            // independent unit, and drops while the access runs.
            bus_clear_out <= (state_d == BUS_REQ) && !independent_dma_unit_owns_bus;
            bus_cycle.active <= (state_d == BUS_CYC) || (state_d == BUS_CYC2);
            bus_cycle.write  <= !is_refresh_sel && cur_req.is_write;
            bus_cycle.word   <= word_op && !byte_bus;
            bus_cycle.upper  <= (state_d == BUS_CYC2);
            bus_cycle.fc     <= is_refresh_sel ? refresh_fc : cur_fc;
            bus_cycle.addr   <= is_refresh_sel ? refresh_addr : cur_req.addr;
            if (!busy_q || start) begin
                chan_done_q <= 1'b0;
            end else if (state_d == BUS_DONE || (want_int && dpram_cp_gnt)) begin
                chan_done_q <= 1'b1;
            end
        end
    end

    assign chan_done = chan_done_q;

    // ------------------------------------------------------------------
    // Bus error capture
    // ------------------------------------------------------------------
    logic       err_hit;
    logic [3:0] err_code;

    assign err_hit  = bus_error && ((state_q == BUS_CYC) || (state_q == BUS_CYC2));
    assign err_code = is_refresh_sel ? BUS_ERROR_CHANNEL_CODE_CODE_REFRESH
                                     : 4'(BUS_ERROR_CHANNEL_CODE_CODE_BASE + {1'b0, chan_idx});

    always_ff @(posedge core_clk) begin
        if (srst || cp_reset_req) begin
            bus_err_pend_q         <= 1'b0;
            bus_error_valid        <= 1'b0;
            bus_error_channel_code <= 4'h0;
        end else begin
            if (err_hit) begin
                bus_err_pend_q         <= 1'b1;
                bus_error_valid        <= 1'b1;
                bus_error_channel_code <= err_code;
            end else if (start && pick == REQ_BUS_ERR) begin
                bus_err_pend_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Dual-port RAM arbitration
    // ------------------------------------------------------------------
    logic host_gnt_w;
    logic cp_gnt_w;

    dpram_arbiter u_dpram_arbiter (
        .core_clk (core_clk),
        .srst     (srst),
        .host_req (host_dpram_req),
        .cp_req   (cp_dpram_req || want_int),
        .host_gnt (host_gnt_w),
        .cp_gnt   (cp_gnt_w)
    );

    assign dpram_host_gnt = host_gnt_w;
    assign dpram_cp_gnt   = cp_gnt_w;

endmodule : serial_dma_request_scheduler
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import serial_dma_channel_pkg::*;
;
    // --------------------
    // Stimulus and checks
    // --------------------
    logic core_clk = 1'b0, srst = 1'b1, cp_reset_req = 1'b0, refresh_req = 1'b0;
    logic command_req = 1'b0, routine_done = 1'b0, byte_bus = 1'b0, bus_halt = 1'b0;
    logic bus_retry = 1'b0, low_latency_bus_clear_mode = 1'b0, host_dpram_req = 1'b0;
    logic cp_dpram_req = 1'b0, independent_dma_unit_owns_bus = 1'b0, slow = 1'b0;
    logic err_en = 1'b0, saw_clr = 1'b0;
    logic [ADDR_W-1:0] refresh_addr = 24'h00A100;
    logic [FC_W-1:0] refresh_fc = 3'h5;
    logic [11:0] fifo_req = 12'h000;
    logic [NUM_CHAN*FC_W-1:0] chan_fc = 18'h3A5C6;
    chan_req_t [NUM_CHAN-1:0] chan_req = '0;
    logic routine_valid, serial_dma_bus_request_internal, bus_grant_acknowledge_out;
    logic bus_clear_out, bus_error_valid, dpram_host_gnt, dpram_cp_gnt, chan_done;
    logic serial_dma_bus_grant_internal, bus_cycle_done, bus_error;
    logic [3:0] routine_sel, bus_error_channel_code;
    bus_cycle_t bus_cycle, last;
    int errors = 0, num_checks = 0, ncyc = 0, tmo = 0;
    serial_dma_request_scheduler u_dut (.core_clk, .srst, .cp_reset_req, .refresh_req,
        .refresh_addr, .refresh_fc, .command_req, .fifo_req, .chan_req, .chan_fc,
        .routine_done, .serial_dma_bus_grant_internal, .independent_dma_unit_owns_bus,
        .bus_cycle_done, .bus_error, .bus_halt, .bus_retry, .byte_bus,
        .low_latency_bus_clear_mode, .host_dpram_req, .cp_dpram_req, .routine_valid,
        .routine_sel, .serial_dma_bus_request_internal, .bus_grant_acknowledge_out,
        .bus_clear_out, .bus_cycle, .bus_error_valid, .bus_error_channel_code,
        .dpram_host_gnt, .dpram_cp_gnt, .chan_done);
    host_bus_model u_host (.core_clk, .srst, .slow, .err_en, .cyc(bus_cycle),
        .req(serial_dma_bus_request_internal), .gnt(serial_dma_bus_grant_internal),
        .done(bus_cycle_done), .err(bus_error));
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        tmo <= tmo + 1;
        if (bus_cycle.active === 1'b1 && bus_cycle_done === 1'b1) begin
            ncyc <= ncyc + 1;
            last <= bus_cycle;
        end
        if (bus_clear_out === 1'b1) saw_clr <= 1'b1;
        if (tmo == 20000) begin
            errors++;
            conclude();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude;
        if (errors == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task automatic do_reset;
        @(posedge core_clk);
        srst <= 1'b1;
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        @(negedge core_clk);
    endtask : do_reset
    task automatic serve(input logic [3:0] exp);
        for (int i = 0; i < 60 && routine_valid !== 1'b1; i++) @(negedge core_clk);
        check(routine_sel, exp);
        @(posedge core_clk);
        routine_done <= 1'b1;
        if (exp > 4'h3) fifo_req[exp - 4'h4] <= 1'b0;
        if (exp == 4'h3) command_req <= 1'b0;
        if (exp == 4'h2) refresh_req <= 1'b0;
        if (exp == 4'h0) cp_reset_req <= 1'b0;
        @(posedge core_clk);
        routine_done <= 1'b0;
        repeat (2) @(negedge core_clk);
    endtask : serve
    task automatic prio_test;
        @(posedge core_clk);
        for (int c = 0; c < NUM_CHAN; c++) chan_req[c] <= '{1'b1, 1'b0, ~c[0], 1'b0, 24'h000400};
        fifo_req <= 12'hFFF;
        command_req <= 1'b1;
        cp_reset_req <= 1'b1;
        serve(4'h0);
        for (int k = 3; k < 16; k++) serve(4'(k));
        check(ncyc, 0);
    endtask : prio_test
    task automatic ext_xfer(input int ch, input logic wide, input logic bb, input logic own);
        logic wr;
        wr = ~ch[0];
        @(posedge core_clk);
        chan_req[ch] <= '{1'b1, 1'b1, wr, wide, 24'h01F0A0};
        byte_bus <= bb;
        slow <= bb;
        independent_dma_unit_owns_bus <= own;
        low_latency_bus_clear_mode <= own;
        fifo_req[ch] <= 1'b1;
        ncyc = 0;
        saw_clr = 1'b0;
        for (int i = 0; i < 90 && chan_done !== 1'b1; i++) @(negedge core_clk);
        check(ncyc, (bb && (!wr || wide)) ? 2 : 1);
        check(last.write, wr);
        if (!bb) check(last.word, !wr || wide);
        check(last.upper, bb && (!wr || wide));
        check(last.fc, chan_fc[ch*3 +: 3]);
        check(last.addr, 24'h01F0A0);
        check(saw_clr, !own);
        serve(4'(ch + 4));
    endtask : ext_xfer
    task automatic dpram_test;
        int h, c;
        h = 0;
        c = 0;
        @(posedge core_clk);
        host_dpram_req <= 1'b1;
        cp_dpram_req <= 1'b1;
        repeat (4) @(negedge core_clk);
        repeat (8) begin
            @(negedge core_clk);
            h += (dpram_host_gnt === 1'b1);
            c += (dpram_cp_gnt === 1'b1);
        end
        check(h, 2);
        check(c, 6);
        @(posedge core_clk);
        host_dpram_req <= 1'b0;
        cp_dpram_req <= 1'b0;
    endtask : dpram_test
    task automatic refresh_test;
        @(posedge core_clk);
        refresh_req <= 1'b1;
        err_en <= 1'b1;
        byte_bus <= 1'b0;
        independent_dma_unit_owns_bus <= 1'b0;
        saw_clr = 1'b0;
        for (int i = 0; i < 60 && bus_error_valid !== 1'b1; i++) @(negedge core_clk);
        check(bus_error_channel_code, 4'h1);
        check({last.write, last.word}, 2'h0);
        check(last.fc, refresh_fc);
        check(last.addr, refresh_addr);
        check(saw_clr, 1'b1);
        err_en <= 1'b0;
        serve(4'h2);
        serve(4'h1);
        do_reset();
        check(bus_error_valid, 1'b0);
    endtask : refresh_test
    task automatic halt_test;
        @(posedge core_clk);
        chan_req[1] <= '{1'b1, 1'b1, 1'b0, 1'b0, 24'h01F0A0};
        byte_bus <= 1'b1;
        slow <= 1'b1;
        independent_dma_unit_owns_bus <= 1'b0;
        fifo_req[1] <= 1'b1;
        ncyc = 0;
        for (int i = 0; i < 60 && bus_cycle.active !== 1'b1; i++) @(negedge core_clk);
        @(posedge core_clk);
        bus_halt <= 1'b1;
        for (int i = 0; i < 90 && chan_done !== 1'b1; i++) @(negedge core_clk);
        check(ncyc, 1);
        check(last.upper, 1'b0);
        @(posedge core_clk);
        bus_halt <= 1'b0;
        serve(4'h5);
    endtask : halt_test
    initial begin
        do_reset();
        prio_test();
        ext_xfer(0, 1'b0, 1'b0, 1'b0);
        ext_xfer(1, 1'b0, 1'b0, 1'b0);
        ext_xfer(2, 1'b1, 1'b1, 1'b0);
        ext_xfer(3, 1'b0, 1'b1, 1'b1);
        ext_xfer(4, 1'b0, 1'b1, 1'b0);
        ext_xfer(5, 1'b0, 1'b0, 1'b1);
        halt_test();
        dpram_test();
        refresh_test();
        conclude();
    end
endmodule : tb_top
`default_nettype wire
